// ---- design/tve_video_out.v ----
// Video output timing generator and its pixel FIFO for a TV encoder.
// What this block does
// [RULE1] One 8-bit Y, U or V per pixel clock.
// [RULE2] Byte bits 7..0 go on lines 17..10.
// [RULE3] Outputs step on 27 MHz encoder pixel clock while enabled.
// [RULE4] Syncs and data ready are active low.
// [RULE5] Line sync falls each row, low one cycle.
// [RULE6] Field sync falls each field, low one+ cycles.
// [RULE7] Odd field: both sync falling edges coincide.
// [RULE8] Even field: field sync falls apart from line.
// [RULE9] Data moves only while line sync is high.
// [RULE10] Data ready low exactly on valid byte cycles.
// [RULE11] After reset: syncs high, data zero, until enabled.
`timescale 1ns/1ps
`default_nettype none
`include "tve_consts.vh"

module tve_fifo #(
  parameter W = `TVE_DATA_W,
  parameter DEPTH = `TVE_FIFO_DEPTH,
  parameter AW = `TVE_FIFO_AW
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  // Depth is cut to the counter's width on purpose; it fits in AW+1 bits.
  localparam [31:0] DEPTH_W = DEPTH;
  localparam [AW:0] FULL = DEPTH_W[AW:0];
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire pop;

  // Handshakes on both sides; pops only when data is held.
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr_reg];

  // Occupancy after this cycle's push and pop.
  always @* begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

  // Storage is written without reset; pointers and flags are reset.
  always @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and occupancy update; ready is registered from next count.
  always @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      count_reg <= count_next;
      in_ready <= (count_next != FULL);
    end
  end
endmodule

module tve_video_out #(
  parameter [10:0] H_ACTIVE = `TVE_H_ACTIVE,
  parameter [10:0] H_BLANK = `TVE_H_BLANK,
  parameter [8:0] V_LINES = `TVE_V_LINES,
  parameter [8:0] V_BLANK = `TVE_V_BLANK,
  parameter [10:0] VS_TICKS = `TVE_VS_TICKS,
  parameter FIFO_DEPTH = `TVE_FIFO_DEPTH,
  parameter FIFO_AW = `TVE_FIFO_AW
) (
  input wire clk,
  input wire rstn,
  input wire ce,
  input wire video_en,
  input wire encoder_pixel_clock,
  input wire pix_valid,
  input wire [7:0] pix_data,
  output wire pix_ready,
  output reg line_sync_n,
  output reg field_sync_n,
  output reg data_ready_n,
  output reg [`TVE_MSB_LINE:`TVE_LSB_LINE] video_data_lines
);
  localparam [10:0] H_LAST = H_ACTIVE + H_BLANK - 11'h001;
  localparam [10:0] H_HALF = (H_ACTIVE + H_BLANK) >> 1;
  localparam [8:0] V_LAST = V_LINES - 9'h001;
  localparam [10:0] VS_LOAD = VS_TICKS - 11'h001;

  reg pclk_s1_reg;
  reg pclk_s2_reg;
  reg pclk_s3_reg;
  reg [10:0] h_reg;
  reg [8:0] v_reg;
  reg odd_reg;
  reg [10:0] vs_cnt_reg;
  wire tick;
  wire active;
  wire fs_start;
  wire take;
  wire fifo_valid;
  wire [7:0] fifo_data;

  // Two-flop synchroniser on the pixel clock pin, then a rising edge
  // detector on the second stage only.
  always @(posedge clk) begin
    if (!rstn) begin
      pclk_s1_reg <= 1'b0;
      pclk_s2_reg <= 1'b0;
      pclk_s3_reg <= 1'b0;
    end else if (ce) begin
      pclk_s1_reg <= encoder_pixel_clock;
      pclk_s2_reg <= pclk_s1_reg;
      pclk_s3_reg <= pclk_s2_reg;
    end
  end

  // Every output update except pix_ready while video_en is high happens on a pixel clock rising edge.
  assign tick = pclk_s2_reg & ~pclk_s3_reg; // [RULE3]
  // Active area sits past horizontal blanking, so line sync is high.
  assign active = (v_reg >= V_BLANK) && (h_reg >= H_BLANK); // [RULE9]
  // Field sync falls with line sync for an odd field, mid-line if even.
  assign fs_start = (v_reg == 9'h000) &&
                    (odd_reg ? (h_reg == 11'h000) : // [RULE7]
                               (h_reg == H_HALF)); // [RULE8]
  // A byte leaves the FIFO only on an active pixel tick.
  assign take = tick & video_en & active;

  tve_fifo #(
    .W(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(pix_valid),
    .in_data(pix_data),
    .in_ready(pix_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(take)
  );

  // Raster counters, field parity and all pin outputs except pix_ready, which comes from the FIFO.
  always @(posedge clk) begin
    if (!rstn) begin
      h_reg <= 11'h000;
      v_reg <= 9'h000;
      odd_reg <= 1'b1;
      vs_cnt_reg <= 11'h000;
      line_sync_n <= 1'b1; // [RULE11]
      field_sync_n <= 1'b1;
      data_ready_n <= 1'b1;
      video_data_lines <= 8'h00;
    end else if (ce) begin
      if (!video_en) begin
        // Idle: restart at a new frame, outputs inactive.
        h_reg <= 11'h000;
        v_reg <= 9'h000;
        odd_reg <= 1'b1;
        vs_cnt_reg <= 11'h000;
        line_sync_n <= 1'b1; // [RULE11]
        field_sync_n <= 1'b1; // [RULE4]
        data_ready_n <= 1'b1;
        video_data_lines <= 8'h00;
      end else if (tick) begin
        if (h_reg == H_LAST) begin
          h_reg <= 11'h000;
          if (v_reg == V_LAST) begin
            v_reg <= 9'h000;
            odd_reg <= ~odd_reg;
          end else begin
            v_reg <= v_reg + 9'h001;
          end
        end else begin
          h_reg <= h_reg + 11'h001;
        end
        // Line sync is low for the single first tick of each row.
        line_sync_n <= (h_reg != 11'h000); // [RULE5] [RULE4]
        // Field sync is held low for VS_TICKS ticks from its edge.
        if (fs_start) begin
          field_sync_n <= 1'b0; // [RULE6]
          vs_cnt_reg <= VS_LOAD;
        end else if (vs_cnt_reg != 11'h000) begin
          field_sync_n <= 1'b0; // [RULE6]
          vs_cnt_reg <= vs_cnt_reg - 11'h001;
        end else begin
          field_sync_n <= 1'b1;
        end
        // One component byte per tick, bit 7 on the top line.
        if (active && fifo_valid) begin
          video_data_lines <= fifo_data; // [RULE1] [RULE2]
          data_ready_n <= 1'b0; // [RULE10]
        end else begin
          video_data_lines <= 8'h00;
          data_ready_n <= 1'b1; // [RULE10] [RULE9]
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- design/tve_consts.vh ----
// Timing, width and depth constants for the video output block.
`ifndef TVE_CONSTS_VH
`define TVE_CONSTS_VH
`define TVE_PIX_CLK_KHZ 32'h0000_6978
`define TVE_DATA_W 8
`define TVE_FIFO_DEPTH 16
`define TVE_FIFO_AW 4
`define TVE_H_ACTIVE 11'h5A0
`define TVE_H_BLANK 11'h114
`define TVE_V_LINES 9'h106
`define TVE_V_BLANK 9'h014
`define TVE_VS_TICKS 11'h008
`define TVE_LSB_LINE 10
`define TVE_MSB_LINE 17
`endif

// ---- testbench/tve_video_out_sva.sv ----
// Checker for the video output timing seen at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module tve_video_out_sva (
  input wire logic clk,
  input wire logic rstn,
  input wire logic pix_ready,
  input wire logic line_sync_n,
  input wire logic field_sync_n,
  input wire logic data_ready_n,
  input wire logic [17:10] video_data_lines
);
  logic odd_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Field parity expected next: odd first, toggling at each field start.
  always @(posedge clk) begin
    if (!rstn) odd_reg <= 1'b1;
    else if ($fell(field_sync_n)) odd_reg <= !odd_reg;
  end
  // One pixel tick is eight system clocks; field sync lasts two ticks.
  sequence s_line_pulse;
    !line_sync_n[*8] ##1 line_sync_n;
  endsequence
  sequence s_field_pulse;
    !field_sync_n[*8] ##1 !field_sync_n[*8] ##1 field_sync_n;
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) !rstn |=>
    line_sync_n && field_sync_n && data_ready_n && video_data_lines == 8'h00)
    else $error("outputs not idle after reset");
  a_line_single: assert property ($fell(line_sync_n) |-> s_line_pulse)
    else $error("line sync pulse length wrong");
  a_field_hold: assert property ($fell(field_sync_n) |-> s_field_pulse)
    else $error("field sync pulse length wrong");
  a_odd_coincide: assert property ($fell(field_sync_n) && odd_reg |->
    $fell(line_sync_n)) else $error("odd field edges apart");
  a_even_apart: assert property ($fell(field_sync_n) && !odd_reg |->
    !$fell(line_sync_n)) else $error("even field edges together");
  a_data_active: assert property (!data_ready_n |-> line_sync_n)
    else $error("byte during line sync");
  a_idle_zero: assert property (data_ready_n |-> video_data_lines == 8'h00)
    else $error("data lines not zero without byte");
  a_byte_stands: assert property ($changed(video_data_lines) |=>
    $stable(video_data_lines)[*7]) else $error("data changed within a tick");
  a_ready_rise: assert property ($rose(rstn) |-> !pix_ready ##1 pix_ready)
    else $error("source ready late after reset");
endmodule
`default_nettype wire

// ---- testbench/tve_enc_model.sv ----
// Encoder model: makes the pixel clock and captures the bytes.
`timescale 1ns/1ps
`default_nettype none
module tve_enc_model (
  output var logic pclk,
  input wire logic line_sync_n,
  input wire logic data_ready_n,
  input wire logic [7:0] vd
);
  logic [7:0] q[$];
  // Free-running pixel clock, offset so it never meets a system edge.
  initial begin
    pclk = 1'b0;
    #7;
    forever #80 pclk = !pclk;
  end
  // A byte counts only with data ready low and line sync high.
  always @(posedge pclk) begin
    if (!data_ready_n && line_sync_n) q.push_back(vd);
  end
endmodule
`default_nettype wire

// ---- testbench/test_tve_video_out.sv ----
// Self-checking bench for the video output block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_tve_video_out;
  logic clk = 1'b0, rstn = 1'b0, video_en = 1'b0, pix_valid = 1'b0;
  logic src_on = 1'b0, ce = 1'b1, pclk, pix_ready, ls_n, fs_n, dr_n;
  logic [7:0] pix_data = 8'h00, vd, exp_b, rx;
  logic [31:0] seed = 32'h0000_0029;
  logic [7:0] exp_q[$];
  int miscompares = 0, n_compared = 0, i, k;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  initial forever #10 clk = !clk;
  tve_video_out #(.H_ACTIVE(11'h010), .H_BLANK(11'h008), .V_LINES(9'h006),
    .V_BLANK(9'h001), .VS_TICKS(11'h002)) dut (.clk(clk), .rstn(rstn),
    .ce(ce), .video_en(video_en), .encoder_pixel_clock(pclk),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_ready(pix_ready),
    .line_sync_n(ls_n), .field_sync_n(fs_n), .data_ready_n(dr_n),
    .video_data_lines(vd));
  tve_enc_model enc (.pclk(pclk), .line_sync_n(ls_n), .data_ready_n(dr_n),
    .vd(vd));
  // Source records each byte taken and draws the next one.
  always @(posedge clk) begin
    if (rstn && ce && pix_valid && pix_ready) begin
      exp_q.push_back(pix_data);
      seed = xs(seed);
      pix_data <= seed[7:0];
    end
    pix_valid <= src_on;
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic idle_chk();
    `CHK("line_sync_n", 1'b1, ls_n)
    `CHK("field_sync_n", 1'b1, fs_n)
    `CHK("data_ready_n", 1'b1, dr_n)
    `CHK("video_data_lines", 8'h00, vd)
  endtask
  // Fill the buffer with video off, then stream, starve and stop.
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 idle_chk();
    @(posedge clk);
    src_on <= 1'b1;
    // Freeze the block mid-fill; any byte it took anyway shows up later.
    repeat (4) @(posedge clk);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    repeat (30) @(posedge clk);
    `CHK("fill", 16, exp_q.size())
    `CHK("pix_ready", 1'b0, pix_ready)
    video_en <= 1'b1;
    for (i = 0; i < 160 && k < 3000; i++) begin
      for (k = 0; k < 3000 && enc.q.size() == 0; k++) @(posedge clk);
      if (k < 3000) begin
        exp_b = exp_q.pop_front();
        rx = enc.q.pop_front();
        `CHK("byte", exp_b, rx)
        if (i == 40) src_on <= 1'b0;
        if (i > 40 && !src_on && exp_q.size() == 0) begin
          repeat (200) @(posedge clk);
          src_on <= 1'b1;
        end
      end
    end
    if (k == 3000) miscompares++;
    for (k = 0; k < 500 && ls_n !== 1'b0; k++) @(posedge clk);
    if (k == 500) miscompares++;
    repeat (20) @(posedge clk);
    video_en <= 1'b0;
    repeat (20) @(posedge clk);
    idle_chk();
    tally_and_finish();
  end
endmodule
bind tve_video_out tve_video_out_sva chk (.clk, .rstn, .pix_ready,
  .line_sync_n, .field_sync_n, .data_ready_n, .video_data_lines);
`default_nettype wire
